//--- design/serial_bcd_rtc_core.sv
// serial bcd real-time clock core: calendar, alarm, watchdog, outputs
// Operation
// - crystal 32.768 khz is the sole time base
// - eight clock bytes, all in bcd
// - twelve control bytes for alarm, watchdog, wave
// - pointer increments after every data byte
// - century to hundredths, hours in 24-hour form
// - date wraps by month length, leap years
// - watchdog timeout 62.5 ms up to 252 s
// - alarm keeps working on battery
// - detect a stopped crystal oscillator
// - set stamp flag when backup begins
// - switch to battery on power failure
// - one open-drain pin shared by four functions
// - i2c slave access, data line bidirectional
// - answer slave address d0h after start
// - pointer steps on ack clock; reads resume
// - clock copy frozen during bus access while pointer at 00h-07h
// - power fail aborts access, resets pointer
`timescale 1ns/10ps
module serial_bcd_rtc_core
   import rtc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // crystal time base and supply monitor
   input wire logic crystal_in,
   input wire logic powerFail,
   // serial bus
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // shared open-drain output
   output logic shared_open_drain_output,
   output logic sharedOe,
   // status
   output logic batteryActive,
   output logic power_down_stamp_flag,
   output logic oscStopped
);
   import rtc_pkg::*;

   typedef struct packed {
      logic [1:0] xs, pfs, cls, das;
      logic xPrev, pfPrev, almPrev, odLvl;
      logic [15:0] acc, div;
      logic [9:0] oscCnt;
      logic [22:0] wdCnt;
      logic [4:0] ptr;
      logic [7:0][7:0] live;
      logic [NREG-1:0][7:0] rf;
   } core_t;

   core_t q, n;
   logic busy, ptrLd, wrStb, ackClk, rdLoad, sdaPull;
   logic [7:0] rxByte, rdByte;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // bcd step with wrap; bit 8 is the carry out
   function automatic logic [8:0] bcdNext(input logic [7:0] v,
      input logic [7:0] last, input logic [7:0] first);
      if (v == last)
         return {1'b1, first};
      else if (v[3:0] == 4'h9)
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      else
         return {1'b0, v + 8'h01};
   endfunction

   // last date of a month; the simple leap test holds up to 2100
   function automatic logic [7:0] monthEnd(input logic [7:0] mon,
      input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
         : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         8'h02: return leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction

   // ------------------------------------------------------------
   // serial bus engine
   // ------------------------------------------------------------

   // inputs are ignored while supply is out of tolerance
   i2c_slave_port bus (
      .clk(clk),
      .nrst(nrst),
      .scl(q.cls[1] | q.pfs[1]),
      .sda(q.das[1] | q.pfs[1]),
      .abort(q.pfs[1]),
      .rdByte(rdByte),
      .busy(busy),
      .ptrLd(ptrLd),
      .wrStb(wrStb),
      .ackClk(ackClk),
      .rdLoad(rdLoad),
      .rxByte(rxByte),
      .sdaPull(sdaPull)
   );

   assign rdByte = q.rf[q.ptr];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------

   always_comb
   begin
      logic xTick, hTick, c, match;
      logic [8:0] r;
      logic [7:0] hr;
      logic [1:0] cen;
      logic [4:0] sh;
      logic [22:0] wdLim;
      logic [3:0] rs;
      xTick = 1'b0;
      hTick = 1'b0;
      c = 1'b0;
      match = 1'b0;
      r = '0;
      hr = '0;
      cen = '0;
      sh = '0;
      wdLim = '0;
      rs = '0;
      n = q;
      // two-stage synchronisers for every pin input
      n.xs = {q.xs[0], crystal_in};
      n.pfs = {q.pfs[0], powerFail};
      n.cls = {q.cls[0], sclIn};
      n.das = {q.das[0], sdaIn};
      n.xPrev = q.xs[1];
      n.pfPrev = q.pfs[1];
      xTick = q.xs[1] & ~q.xPrev;

      // crystal divider and a fractional hundredths accumulator:
      // 32768 is not a multiple of 100, so ticks average out exactly
      if (xTick)
      begin
         n.div = q.div + 16'h0001;
         if (q.acc + HUND_STEP >= XTAL_WRAP)
         begin
            n.acc = q.acc + HUND_STEP - XTAL_WRAP;
            hTick = 1'b1;
         end
         else
            n.acc = q.acc + HUND_STEP;
      end

      // oscillator stop watch
      if (xTick)
         n.oscCnt = '0;
      else if (q.oscCnt != OSC_STOP_CYC)
         n.oscCnt = q.oscCnt + 10'h001;

      // calendar cascade, runs on battery as well
      if (hTick)
      begin
         r = bcdNext(q.live[A_HUND], L_HUND, B_ZERO);
         n.live[A_HUND] = r[7:0];
         c = r[8];
         if (c)
         begin
            r = bcdNext(q.live[A_SEC], L_SEC, B_ZERO);
            n.live[A_SEC] = r[7:0];
            c = r[8];
         end
         if (c)
         begin
            r = bcdNext(q.live[A_MIN], L_SEC, B_ZERO);
            n.live[A_MIN] = r[7:0];
            c = r[8];
         end
         cen = q.live[A_HOUR][7:6];
         if (c)
         begin
            hr = {2'b00, q.live[A_HOUR][5:0]};
            r = bcdNext(hr, L_HOUR, B_ZERO);
            n.live[A_HOUR][5:0] = r[5:0];
            c = r[8];
         end
         if (c)
         begin
            r = bcdNext(q.live[A_DAY], L_DAY, B_ONE);
            n.live[A_DAY] = r[7:0];
            r = bcdNext(q.live[A_DATE],
               monthEnd(q.live[A_MON], q.live[A_YEAR]), B_ONE);
            n.live[A_DATE] = r[7:0];
            c = r[8];
         end
         if (c)
         begin
            r = bcdNext(q.live[A_MON], L_MON, B_ONE);
            n.live[A_MON] = r[7:0];
            c = r[8];
         end
         if (c)
         begin
            r = bcdNext(q.live[A_YEAR], L_YEAR, B_ZERO);
            n.live[A_YEAR] = r[7:0];
            n.live[A_HOUR][7:6] = cen + {1'b0, r[8]};
         end
      end

      // user copy follows the live time unless frozen
      if (!(busy && q.ptr <= A_YEAR) && !q.rf[A_FLAGS][F_STAMP])
         for (int i = 0; i < 8; i++)
            n.rf[i] = q.live[i];

      // register writes
      if (wrStb)
      begin
         if (q.ptr <= A_YEAR)
         begin
            n.live[q.ptr[2:0]] = rxByte;
            n.rf[q.ptr] = rxByte;
            if (q.ptr == A_HUND)
               n.acc = '0;
         end
         else if (q.ptr == A_FLAGS)
         begin
            // status bits are clear-only from the bus
            n.rf[A_FLAGS][F_OSC] = q.rf[A_FLAGS][F_OSC] & rxByte[F_OSC];
            n.rf[A_FLAGS][F_STAMP] =
               q.rf[A_FLAGS][F_STAMP] & rxByte[F_STAMP];
         end
         else
            n.rf[q.ptr] = rxByte;
         if (q.ptr == A_WDOG)
            n.wdCnt = '0;  // a write restarts the watchdog unless a crystal tick falls in the same cycle
      end
      // reading flags clears alarm and watchdog events
      if (rdLoad && q.ptr == A_FLAGS)
      begin
         n.rf[A_FLAGS][F_ALARM] = 1'b0;
         n.rf[A_FLAGS][F_WDOG] = 1'b0;
      end

      // address pointer
      if (q.pfs[1])
         n.ptr = '0;
      else if (ptrLd)
         n.ptr = (rxByte > {3'b000, A_LAST}) ? 5'h00 : rxByte[4:0];
      else if (ackClk)
         n.ptr = (q.ptr == A_LAST) ? 5'h00 : q.ptr + 5'h01;

      // watchdog: multiplier times resolution of 1/16, 1/4, 1 or 4 s
      sh = WD_SHIFT0 + {2'b00, q.rf[A_WDOG][1:0], 1'b0};
      wdLim = 23'(q.rf[A_WDOG][7:2]) << sh;
      if (q.rf[A_WDOG][7:2] == 6'h00)
         n.wdCnt = '0;
      else if (xTick)
      begin
         if (q.wdCnt + 23'h00_0001 >= wdLim)
         begin
            n.wdCnt = '0;
            n.rf[A_FLAGS][F_WDOG] = 1'b1;
         end
         else
            n.wdCnt = q.wdCnt + 23'h00_0001;
      end

      // alarm compares live time; flag set on the first matching cycle
      match = q.live[A_SEC] == q.rf[A_ASEC]
         && q.live[A_MIN] == q.rf[A_AMIN]
         && q.live[A_HOUR][5:0] == q.rf[A_AHOUR][5:0]
         && q.live[A_DATE] == q.rf[A_ADATE]
         && q.live[A_MON] == {1'b0, q.rf[A_AMON][6:0]};
      n.almPrev = match;
      // hardware sets are applied last so they win over clears
      if (match && !q.almPrev)
         n.rf[A_FLAGS][F_ALARM] = 1'b1;
      if (q.oscCnt == OSC_STOP_CYC)
         n.rf[A_FLAGS][F_OSC] = 1'b1;
      if (q.pfs[1] && !q.pfPrev)
         n.rf[A_FLAGS][F_STAMP] = 1'b1;

      // shared pin: square wave first, then interrupt, test, port bit
      rs = q.rf[A_SQW][7:4];
      if (rs != 4'h0)
         n.odLvl = q.div[rs - 4'h1];
      else if ((q.rf[A_FLAGS][F_ALARM] && q.rf[A_AMON][ALM_EN])
         || q.rf[A_FLAGS][F_WDOG])
         n.odLvl = 1'b0;
      else if (q.rf[A_CAL][CAL_FT])
         n.odLvl = q.div[FT_TAP];
      else
         n.odLvl = q.rf[A_CAL][CAL_OUT];
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         q <= '0;
         q.cls <= 2'b11;
         q.das <= 2'b11;
         q.odLvl <= 1'b1;
         q.live[A_DAY] <= B_ONE;
         q.live[A_DATE] <= B_ONE;
         q.live[A_MON] <= B_ONE;
      end
      else
         q <= n;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------

   // open drain: only ever pull low
   assign sdaOut = 1'b0;
   assign sdaOe = sdaPull;
   assign shared_open_drain_output = 1'b0;
   assign sharedOe = ~q.odLvl;
   assign batteryActive = q.pfs[1];
   assign power_down_stamp_flag = q.rf[A_FLAGS][F_STAMP];
   assign oscStopped = q.rf[A_FLAGS][F_OSC];
endmodule

//--- design/rtc_pkg.sv
// shared constants of the serial bcd real-time clock core
package rtc_pkg;
   // time base
   localparam int CLK_HZ = 10_000_000;
   localparam int XTAL_HZ = 32768;
   localparam int HUND_HZ = 100;
   localparam logic [15:0] HUND_STEP = 16'(HUND_HZ);
   localparam logic [15:0] XTAL_WRAP = 16'(XTAL_HZ);
   // crystal declared stopped after this long without a rising edge
   localparam int OSC_STOP_US = 100;
   localparam logic [9:0] OSC_STOP_CYC =
      10'((OSC_STOP_US * (CLK_HZ / 1_000_000)));
   // serial bus
   localparam logic [6:0] SLAVE_ID = 7'h68;  // d0h with r/w appended
   localparam int NREG = 20;
   // register map
   localparam logic [4:0] A_HUND = 5'h00;
   localparam logic [4:0] A_SEC = 5'h01;
   localparam logic [4:0] A_MIN = 5'h02;
   localparam logic [4:0] A_HOUR = 5'h03;
   localparam logic [4:0] A_DAY = 5'h04;
   localparam logic [4:0] A_DATE = 5'h05;
   localparam logic [4:0] A_MON = 5'h06;
   localparam logic [4:0] A_YEAR = 5'h07;
   localparam logic [4:0] A_CAL = 5'h08;
   localparam logic [4:0] A_WDOG = 5'h09;
   localparam logic [4:0] A_AMON = 5'h0a;
   localparam logic [4:0] A_ADATE = 5'h0b;
   localparam logic [4:0] A_AHOUR = 5'h0c;
   localparam logic [4:0] A_AMIN = 5'h0d;
   localparam logic [4:0] A_ASEC = 5'h0e;
   localparam logic [4:0] A_FLAGS = 5'h0f;
   localparam logic [4:0] A_SQW = 5'h13;
   localparam logic [4:0] A_LAST = 5'h13;
   // field positions
   localparam int F_WDOG = 7;
   localparam int F_ALARM = 6;
   localparam int F_STAMP = 5;
   localparam int F_OSC = 2;
   localparam int CAL_OUT = 7;
   localparam int CAL_FT = 6;
   localparam int ALM_EN = 7;
   localparam int FT_TAP = 5;  // 512 hz test tap of the crystal divider
   localparam logic [4:0] WD_SHIFT0 = 5'h0b;  // 1/16 s in crystal ticks
   // bcd limits
   localparam logic [7:0] B_ZERO = 8'h00;
   localparam logic [7:0] B_ONE = 8'h01;
   localparam logic [7:0] L_HUND = 8'h99;
   localparam logic [7:0] L_SEC = 8'h59;
   localparam logic [7:0] L_HOUR = 8'h23;
   localparam logic [7:0] L_DAY = 8'h07;
   localparam logic [7:0] L_MON = 8'h12;
   localparam logic [7:0] L_YEAR = 8'h99;
endpackage

//--- design/i2c_slave_port.sv
// serial bus slave engine: start, stop, address, ack, byte shifting
`timescale 1ns/10ps
module i2c_slave_port
   import rtc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // synchronised bus lines and abort
   input wire logic scl,
   input wire logic sda,
   input wire logic abort,
   // register side
   input wire logic [7:0] rdByte,
   output logic busy,
   output logic ptrLd,
   output logic wrStb,
   output logic ackClk,
   output logic rdLoad,
   output logic [7:0] rxByte,
   // data line pull-down
   output logic sdaPull
);
   import rtc_pkg::*;

   typedef enum logic [8:0] {
      IDLE = 9'b0_0000_0001, ADDR = 9'b0_0000_0010,
      ADACK = 9'b0_0000_0100, PTR = 9'b0_0000_1000,
      PTACK = 9'b0_0001_0000, WDAT = 9'b0_0010_0000,
      WDACK = 9'b0_0100_0000, RDAT = 9'b0_1000_0000,
      RDACK = 9'b1_0000_0000
   } slv_state_t;

   typedef struct packed {
      slv_state_t st;
      logic sclP, sdaP, rw, nack, drv;
      logic ptrLd, wrStb, ackClk, rdLoad;
      logic [3:0] cnt;
      logic [7:0] sh, rx;
   } slv_t;

   slv_t q, n;
   logic rise, fall, startC, stopC;

   // bus events from the synchronised lines
   assign rise = scl & ~q.sclP;
   assign fall = ~scl & q.sclP;
   assign startC = scl & q.sclP & q.sdaP & ~sda;
   assign stopC = scl & q.sclP & ~q.sdaP & sda;

   // next-state of the byte engine
   always_comb
   begin
      n = q;
      n.sclP = scl;
      n.sdaP = sda;
      {n.ptrLd, n.wrStb, n.ackClk, n.rdLoad} = 4'h0;
      if (abort || stopC)
      begin
         n.st = IDLE;
         n.drv = 1'b0;
      end
      else if (startC)
      begin
         n.st = ADDR;
         n.cnt = 4'h0;
         n.drv = 1'b0;
      end
      else
      begin
         unique case (q.st)
            IDLE: n.drv = 1'b0;
            ADDR, PTR, WDAT:
               if (rise)
               begin
                  n.sh = {q.sh[6:0], sda};
                  n.cnt = q.cnt + 4'h1;
               end
               else if (fall && q.cnt == 4'h8)
               begin
                  n.drv = 1'b1;
                  n.rx = q.sh;
                  if (q.st == ADDR)
                  begin
                     n.rw = q.sh[0];
                     n.st = (q.sh[7:1] == SLAVE_ID) ? ADACK : IDLE;
                     n.drv = (q.sh[7:1] == SLAVE_ID);
                  end
                  else if (q.st == PTR)
                  begin
                     n.ptrLd = 1'b1;
                     n.st = PTACK;
                  end
                  else
                  begin
                     n.wrStb = 1'b1;
                     n.st = WDACK;
                  end
               end
            ADACK, PTACK, WDACK, RDACK:
               if (rise)
               begin
                  n.nack = sda;
                  // pointer steps only on a data byte's ack clock
                  n.ackClk = (q.st == WDACK || q.st == RDACK);
               end
               else if (fall)
               begin
                  n.cnt = 4'h0;
                  n.drv = 1'b0;
                  n.st = (q.st == ADACK) ? PTR : WDAT;
                  if ((q.st == ADACK && q.rw) || q.st == RDACK)
                  begin
                     n.st = (q.st == RDACK && q.nack) ? IDLE : RDAT;
                     n.rdLoad = (n.st == RDAT);
                     n.sh = rdByte;
                     n.drv = (n.st == RDAT) & ~rdByte[7];
                  end
               end
            RDAT:
               if (fall)
               begin
                  n.cnt = q.cnt + 4'h1;
                  n.sh = {q.sh[6:0], 1'b1};
                  n.drv = ~q.sh[6];
                  if (q.cnt == 4'h7)
                  begin
                     n.drv = 1'b0;  // release for master ack
                     n.st = RDACK;
                  end
               end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         q <= '0;
         q.st <= IDLE;
         q.sclP <= 1'b1;
         q.sdaP <= 1'b1;
      end
      else
         q <= n;
   end

   assign busy = (q.st != IDLE);
   assign ptrLd = q.ptrLd;
   assign wrStb = q.wrStb;
   assign ackClk = q.ackClk;
   assign rdLoad = q.rdLoad;
   assign rxByte = q.rx;
   assign sdaPull = q.drv;
endmodule

//--- verif/rtc_core_chk.sv
// assertion checker watching the rtc core pins
`timescale 1ns/10ps
module rtc_core_chk
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // pins watched
   input wire logic crystal_in,
   input wire logic powerFail,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic shared_open_drain_output,
   input wire logic sharedOe,
   input wire logic batteryActive,
   input wire logic power_down_stamp_flag,
   input wire logic oscStopped
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ------------------------------
   // helper: cycles since crystal moved
   // ------------------------------
   logic [10:0] idleCnt_q;
   logic xtalPrev_q;
   // saturates so a long stop cannot wrap back
   always_ff @(posedge clk)
   begin
      xtalPrev_q <= crystal_in;
      if (!nrst || crystal_in != xtalPrev_q)
         idleCnt_q <= 11'h000;
      else if (idleCnt_q != 11'h7ff)
         idleCnt_q <= idleCnt_q + 11'h001;
   end
   // outputs quiet on leaving reset
   a_reset_clean: assert property ($rose(nrst) |-> !sdaOe && !sharedOe
      && !batteryActive && !power_down_stamp_flag && !oscStopped)
      else $error("outputs not quiet after reset");
   a_sda_drain: assert property (sdaOe |-> !sdaOut)
      else $error("data pin driven high");
   a_pin_drain: assert property (sharedOe |-> !shared_open_drain_output)
      else $error("shared pin driven high");
   a_battery_on: assert property (powerFail [*5] |=> batteryActive)
      else $error("no switch to battery");
   a_battery_off: assert property (!powerFail [*5] |=> !batteryActive)
      else $error("battery kept without power fail");
   a_stamp_sets: assert property (
      $rose(batteryActive) |-> ##[0:2] power_down_stamp_flag)
      else $error("stamp flag not set on backup");
   a_stamp_holds: assert property (
      power_down_stamp_flag && batteryActive |=> power_down_stamp_flag)
      else $error("stamp flag lost during backup");
   a_bus_ignored: assert property (batteryActive [*3] |-> !sdaOe)
      else $error("bus answered during power fail");
   a_sda_moves_low: assert property (
      $changed(sdaOe) |-> !sclIn && !$past(sclIn, 2))
      else $error("data changed while clock high");
   a_osc_detect: assert property (idleCnt_q >= 11'h3fc |-> oscStopped)
      else $error("crystal idle but fail flag low");
endmodule
bind serial_bcd_rtc_core rtc_core_chk u_chk (.clk(clk), .nrst(nrst),
   .crystal_in(crystal_in), .powerFail(powerFail), .sclIn(sclIn),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .sharedOe(sharedOe),
   .shared_open_drain_output(shared_open_drain_output),
   .batteryActive(batteryActive), .oscStopped(oscStopped),
   .power_down_stamp_flag(power_down_stamp_flag));

//--- verif/i2c_master_model.sv
// behavioural serial bus master facing the rtc core
`timescale 1ns/10ps
module i2c_master_model
(
   // clock
   input wire logic clk,
   // bus lines
   output logic sclIn,
   output logic sdaIn,
   input wire logic sdaOe
);
   logic pull;
   // wired data line with pull-up: any party pulling wins
   assign sdaIn = !(pull || sdaOe);
   initial
   begin
      pull = 1'b0;
      sclIn = 1'b1;
   end
   // all moves land just after a clock edge
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #1;
      end
   endtask
   // start, or repeated start from a low clock
   task automatic start();
      tick(2);
      pull = 1'b0;
      tick(6);
      sclIn = 1'b1;
      tick(6);
      pull = 1'b1;
      tick(6);
      sclIn = 1'b0;
   endtask
   task automatic stop();
      tick(2);
      pull = 1'b1;
      tick(4);
      sclIn = 1'b1;
      tick(6);
      pull = 1'b0;
      tick(6);
   endtask
   // data set while clock low, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      pull = !b;
      tick(4);
      sclIn = 1'b1;
      tick(3);
      r = sdaIn;
      tick(3);
      sclIn = 1'b0;
   endtask
   // byte out msb first, then the slave's acknowledge
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // byte in; the last one gets a no-acknowledge
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the serial bcd rtc core
`timescale 1ns/10ps
module tb;
   import rtc_pkg::*;
   logic clk, nrst, crystal_in, powerFail, xtalRun, ack;
   logic sclIn, sdaIn, sdaOut, sdaOe, sharedOut, sharedOe;
   logic batteryActive, stampFlag, oscStopped;
   logic [1:0] cen, nCen;
   logic [7:0] dayV, mon, yr, nMon, nYr;
   logic [31:0] lfsr;
   logic [7:0] rdBuf [0:7];
   logic [7:0] wrBuf [0:7];
   logic [23:0] cases [0:4];
   int fail_count, checks;
   serial_bcd_rtc_core u_serial_bcd_rtc_core (.clk(clk), .nrst(nrst),
      .crystal_in(crystal_in), .powerFail(powerFail), .sclIn(sclIn),
      .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .sharedOe(sharedOe),
      .shared_open_drain_output(sharedOut), .batteryActive(batteryActive),
      .power_down_stamp_flag(stampFlag), .oscStopped(oscStopped));
   i2c_master_model u_master (.clk(clk), .sclIn(sclIn), .sdaIn(sdaIn),
      .sdaOe(sdaOe));
   // ------------------------------
   // clocks and helpers
   // ------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // crystal offset from clk so its edges never meet a sampling edge
   initial
   begin
      crystal_in = 1'b0;
      #137;
      forever
      begin
         #400;
         if (xtalRun)
            crystal_in = ~crystal_in;
      end
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
   endfunction
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v == 8'h99)
         return 8'h00;
      return (v[3:0] == 4'h9) ? v + 8'h07 : v + 8'h01;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // write n bytes of wrBuf from ptr; n of zero only moves the pointer
   task automatic wr_regs(input logic [7:0] ptr, input int n);
      u_master.start();
      u_master.send({SLAVE_ID, 1'b0}, ack);
      check(ack, 1'b1);
      u_master.send(ptr, ack);
      check(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         u_master.send(wrBuf[i], ack);
         check(ack, 1'b1);
      end
      u_master.stop();
   endtask
   // read n bytes; fresh reads go on from the stored pointer
   task automatic rd_regs(input logic [7:0] ptr, input logic fresh,
      input int n);
      if (!fresh)
      begin
         u_master.start();
         u_master.send({SLAVE_ID, 1'b0}, ack);
         u_master.send(ptr, ack);
      end
      u_master.start();
      u_master.send({SLAVE_ID, 1'b1}, ack);
      check(ack, 1'b1);
      for (int i = 0; i < n; i++)
         u_master.recv(i == n - 1, rdBuf[i]);
      u_master.stop();
   endtask
   // hang guard, well past the expected run length
   initial
   begin
      repeat (100000) @(posedge clk);
      fail_count++;
      complete_run();
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial
   begin
      nrst = 1'b0;
      powerFail = 1'b0;
      xtalRun = 1'b1;
      fail_count = 0;
      checks = 0;
      lfsr = 32'h0001_3505;
      cases = '{24'h02_0328, 24'h02_0429, 24'h04_0330, 24'h12_9931,
         24'h09_5030};
      repeat (20) @(posedge clk);
      #1;
      nrst = 1'b1;
      cyc(4);
      check(sdaOe, 1'b0);
      check(batteryActive, 1'b0);
      // foreign address must be ignored
      u_master.start();
      u_master.send({SLAVE_ID ^ 7'h01, 1'b0}, ack);
      check(ack, 1'b0);
      u_master.stop();
      // last instant of a month, then read back after the carry
      for (int k = 0; k < 5; k++)
      begin
         lfsr = lfsr_next(lfsr);
         cen = {1'b0, lfsr[2]};
         dayV = {5'h00, (lfsr[5:3] == 3'h0) ? 3'h7 : lfsr[5:3]};
         {mon, yr, wrBuf[5]} = cases[k];
         wrBuf[0] = 8'h99;
         wrBuf[1] = 8'h59;
         wrBuf[2] = 8'h59;
         wrBuf[3] = {cen, 6'h23};
         wrBuf[4] = dayV;
         wrBuf[6] = mon;
         wrBuf[7] = yr;
         wr_regs(8'(A_HUND), 8);
         cyc(2500);
         rd_regs(8'(A_HUND), 1'b0, 8);
         nMon = (mon == 8'h12) ? 8'h01 : bcd_inc(mon);
         nYr = (mon == 8'h12) ? bcd_inc(yr) : yr;
         nCen = (mon == 8'h12 && yr == 8'h99) ? cen + 2'h1 : cen;
         for (int i = 0; i < 3; i++)
            check(rdBuf[i], 8'h00);
         check(rdBuf[3], {nCen, 6'h00});
         check(rdBuf[4], (dayV == 8'h07) ? 8'h01 : dayV + 8'h01);
         check(rdBuf[5], 8'h01);
         check(rdBuf[6], nMon);
         check(rdBuf[7], nYr);
      end
      // random plain bytes, read back without a pointer write
      for (int i = 0; i < 3; i++)
      begin
         lfsr = lfsr_next(lfsr);
         wrBuf[i] = lfsr[7:0];
      end
      wr_regs(8'h10, 3);
      wr_regs(8'h10, 0);
      rd_regs(8'h00, 1'b1, 3);
      for (int i = 0; i < 3; i++)
         check(rdBuf[i], wrBuf[i]);
      // shortest watchdog span: 2048 crystal edges of 8 cycles
      wrBuf[0] = 8'h80;
      wrBuf[1] = 8'h04;
      wr_regs(8'(A_CAL), 2);
      cyc(15000);
      check(sharedOe, 1'b0);
      cyc(2000);
      check(sharedOe, 1'b1);
      rd_regs(8'(A_FLAGS), 1'b0, 1);
      check(rdBuf[0], 8'h80);
      check(sharedOe, 1'b0);
      // watchdog off; alarm on the present month and date, enabled
      wrBuf[0] = 8'h00;
      wrBuf[1] = 8'h80 | nMon;
      wrBuf[2] = 8'h01;
      for (int i = 3; i < 6; i++)
         wrBuf[i] = 8'h00;
      wr_regs(8'(A_WDOG), 6);
      check(sharedOe, 1'b1);
      rd_regs(8'(A_FLAGS), 1'b0, 1);
      check(rdBuf[0], 8'h40);
      check(sharedOe, 1'b0);
      // square wave at half the crystal rate overrides the port bit
      wrBuf[0] = 8'h10;
      wr_regs(8'(A_SQW), 1);
      yr = {7'h00, sharedOe};
      cyc(8);
      check(sharedOe, !yr[0]);
      // stopped crystal
      xtalRun = 1'b0;
      cyc(1200);
      check(oscStopped, 1'b1);
      xtalRun = 1'b1;
      // supply failure: battery, stamp, deaf bus
      powerFail = 1'b1;
      cyc(10);
      check(batteryActive, 1'b1);
      check(stampFlag, 1'b1);
      u_master.start();
      u_master.send({SLAVE_ID, 1'b0}, ack);
      check(ack, 1'b0);
      u_master.stop();
      powerFail = 1'b0;
      cyc(10);
      check(batteryActive, 1'b0);
      check(stampFlag, 1'b1);
      complete_run();
   end
endmodule
